//--- pin_share.sv
// boot-strap capture, mode selection and shared pin muxing
// assumes pad inputs synchronous to mclk; pads resolved outside
`timescale 1ns/10ps
`default_nettype none
`include "pin_share_cfg.svh"
module pin_share
  import pin_share_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // programmable flag pads, low four double as straps
  input  wire logic [`FLAG_W-1:0]       flag_pad_in,
  output var  logic [`FLAG_W-1:0]       flag_pad_out,
  output var  logic [`FLAG_W-1:0]       flag_pad_oe,
  input  wire logic [`FLAG_W-1:0]       flag_dir,
  input  wire logic [`FLAG_W-1:0]       flag_value,
  output var  logic [`FLAG_W-1:0]       flag_read,
  // always-output flags
  input  wire logic [`FIXED_FLAG_W-1:0] fixed_flag_value,
  output var  logic [`FIXED_FLAG_W-1:0] fixed_output_flags,
  // interrupt controls and requests
  input  wire logic [`IRQ_N-1:0]        interrupt_mask_bits,
  input  wire logic                     cfg_irq_edge_sel,
  input  wire logic [1:0]               sport_irq_edge_sel,
  output var  logic [`IRQ_N-1:0]        irq_request,
  // captured strap state
  output var  logic                     mode_host,
  output var  logic [`STRAP_W-1:0]      strap_captured,
  // external address bus
  input  wire logic [`EXT_ADDR_W-1:0]   core_addr,
  output var  logic [`EXT_ADDR_W-1:0]   ext_address_bus,
  output var  logic [`EXT_ADDR_W-1:0]   ext_address_oe,
  // external data bus
  input  wire logic [`EXT_DATA_W-1:0]   core_wdata,
  input  wire logic                     core_drive_data,
  input  wire logic                     byte_access,
  input  wire logic [`BYTE_ADDR_W-1:0]  byte_addr_hi,
  input  wire logic [`EXT_DATA_W-1:0]   ext_data_in,
  output var  logic [`EXT_DATA_W-1:0]   ext_data_out,
  output var  logic [`EXT_DATA_W-1:0]   ext_data_oe,
  output var  logic [`EXT_DATA_W-1:0]   core_rdata,
  // host memory access port bus
  input  wire logic [`HOST_BUS_W-1:0]   host_bus_in,
  input  wire logic [`HOST_BUS_W-1:0]   host_bus_wdata,
  input  wire logic                     host_bus_drive,
  output var  logic [`HOST_BUS_W-1:0]   host_addr_data_bus,
  output var  logic                     host_bus_oe,
  output var  logic [`HOST_BUS_W-1:0]   host_bus_rdata,
  // second serial port pads and core side
  input  wire logic                     sport_flag_mode,
  input  wire logic                     sp1_rfs_in,
  input  wire logic                     sp1_tfs_in,
  input  wire logic                     sp1_dr_in,
  output var  logic                     sp1_dt_out,
  input  wire logic                     sport_dt_core,
  input  wire logic                     serial_flag_output,
  output var  logic                     serial_flag_input,
  output var  logic                     sport_rfs_core,
  output var  logic                     sport_tfs_core,
  output var  logic                     sport_dr_core
);
  // pad level seen by the irq logic: own drive wins over pad
  function automatic logic pad_level(input logic oe, input logic drv,
                                     input logic pin);
    pad_level = oe ? drv : pin;
  endfunction

  // ---------------- strap capture ----------------
  // no async reset: must load a pad level, so it samples on
  // clock edges while rstn is low; the last such edge wins
  logic [`STRAP_W-1:0] strap_ff;
  logic [`STRAP_W-1:0] nxt_strap;
  op_mode_e            op_mode;    // decoded mode, fixed after reset

  // sample only during reset, hold afterwards
  always_comb begin
    if (!rstn) begin
      nxt_strap = flag_pad_in[`STRAP_W-1:0]; // R1 R15
    end else begin
      nxt_strap = strap_ff; // R3
    end
  end

  // relies on the board holding straps steady in reset
  always_ff @(posedge mclk) begin
    strap_ff <= nxt_strap; // R16
  end

  // zero on the memory-mode strap means full memory mode
  assign op_mode = (strap_ff[`MODE_C_BIT] == `FULL_MODE_CODE) ?
                   MODE_FULL : MODE_HOST; // R4

  // ---------------- flag pads ----------------
  flag_pad_s                 flag_ff;       // flag pad drivers
  flag_pad_s                 nxt_flag;
  logic [`FLAG_W-1:0]        flag_read_ff;  // sampled flag levels
  logic [`FLAG_W-1:0]        nxt_flag_read;
  logic [`FIXED_FLAG_W-1:0]  fixed_ff;      // fixed output flags
  logic [`FIXED_FLAG_W-1:0]  nxt_fixed;
  logic                      mode_ff;       // mode status output
  logic                      nxt_mode;
  logic [`STRAP_W-1:0]       strap_out_ff;  // strap status output
  logic [`STRAP_W-1:0]       nxt_strap_out;

  // after reset every strap pin is an ordinary flag
  always_comb begin
    nxt_flag.out   = flag_value;         // R2
    nxt_flag.oe    = flag_dir;           // R2
    nxt_flag_read  = flag_pad_in;        // R8
    nxt_fixed      = fixed_flag_value;   // R13
    nxt_mode       = op_mode;
    nxt_strap_out  = strap_ff;
  end

  // pads float as inputs while reset holds them as straps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_ff      <= '0;
      flag_read_ff <= '0;
      fixed_ff     <= '0;
      mode_ff      <= 1'b0;
      strap_out_ff <= '0;
    end else begin
      flag_ff      <= nxt_flag;
      flag_read_ff <= nxt_flag_read;
      fixed_ff     <= nxt_fixed;
      mode_ff      <= nxt_mode;
      strap_out_ff <= nxt_strap_out;
    end
  end

  assign flag_pad_out       = flag_ff.out;
  assign flag_pad_oe        = flag_ff.oe;
  assign flag_read          = flag_read_ff;
  assign fixed_output_flags = fixed_ff;  // R13
  assign mode_host          = mode_ff;
  assign strap_captured     = strap_out_ff;

  // ---------------- interrupt lanes ----------------
  logic [`IRQ_N-1:0] lane_level;  // active-low level per lane
  logic [`IRQ_N-1:0] lane_edge;   // edge select per lane

  // flag drive loops back, so software can raise its own irq
  always_comb begin
    lane_level = '1;
    lane_level[`LANE_CFG_IRQ] = pad_level(flag_ff.oe[`PIN_CFG_IRQ],
      flag_ff.out[`PIN_CFG_IRQ], flag_pad_in[`PIN_CFG_IRQ]); // R8 R9
    lane_level[`LANE_LVL_ZERO] = pad_level(flag_ff.oe[`PIN_LVL_ZERO],
      flag_ff.out[`PIN_LVL_ZERO], flag_pad_in[`PIN_LVL_ZERO]); // R8
    lane_level[`LANE_LVL_ONE] = pad_level(flag_ff.oe[`PIN_LVL_ONE],
      flag_ff.out[`PIN_LVL_ONE], flag_pad_in[`PIN_LVL_ONE]); // R8
    lane_level[`LANE_EDGE] = pad_level(flag_ff.oe[`PIN_EDGE],
      flag_ff.out[`PIN_EDGE], flag_pad_in[`PIN_EDGE]); // R8
    // serial pins act as irqs only when reassigned
    lane_level[`LANE_SP_IRQ0] = sport_flag_mode ? sp1_rfs_in : 1'b1; // R10
    lane_level[`LANE_SP_IRQ1] = sport_flag_mode ? sp1_tfs_in : 1'b1; // R10
    lane_edge = '0;
    lane_edge[`LANE_CFG_IRQ] = cfg_irq_edge_sel;
    lane_edge[`LANE_SP_IRQ0] = sport_irq_edge_sel[0];
    lane_edge[`LANE_SP_IRQ1] = sport_irq_edge_sel[1];
  end

  // level, edge or configurable sensing per lane is fixed in hardware
  localparam int LANE_SENSE [`IRQ_N] = '{`SENSE_CONFIG, `SENSE_LEVEL,
    `SENSE_LEVEL, `SENSE_EDGE, `SENSE_CONFIG, `SENSE_CONFIG}; // R12

  for (genvar i = 0; i < `IRQ_N; i++) begin : g_lane
    irq_sense #(
      .SENSE (LANE_SENSE[i])
    ) u_sense (
      .mclk      (mclk),
      .rstn      (rstn),
      .pin_level (lane_level[i]),
      .edge_sel  (lane_edge[i]),
      .mask_en   (interrupt_mask_bits[i]),
      .req       (irq_request[i])
    );
  end

  // ---------------- memory interface ----------------
  logic [`EXT_ADDR_W-1:0] addr_ff;      // address pad value
  logic [`EXT_ADDR_W-1:0] addr_oe_ff;   // address pad enables
  logic [`EXT_ADDR_W-1:0] nxt_addr;
  logic [`EXT_ADDR_W-1:0] nxt_addr_oe;
  data_pad_s              data_ff;      // data pad drivers
  data_pad_s              nxt_data;
  logic [`EXT_DATA_W-1:0] rdata_ff;     // data returned to core
  logic [`EXT_DATA_W-1:0] nxt_rdata;
  logic [`HOST_BUS_W-1:0] host_ff;      // host bus pad value
  logic                   host_oe_ff;   // host bus pad enable
  logic [`HOST_BUS_W-1:0] host_rd_ff;   // host bus sampled
  logic [`HOST_BUS_W-1:0] nxt_host;
  logic                   nxt_host_oe;
  logic [`HOST_BUS_W-1:0] nxt_host_rd;

  // mode steers which buses exist; the core cannot override it
  always_comb begin
    nxt_addr    = core_addr;
    nxt_addr_oe = '0;
    nxt_data    = '0;
    nxt_rdata   = '0;
    nxt_host    = host_bus_wdata;
    nxt_host_oe = 1'b0;
    nxt_host_rd = '0;
    if (op_mode == MODE_FULL) begin
      nxt_addr_oe = '1; // R6
      nxt_data.out = core_wdata; // R7
      nxt_data.oe  = core_drive_data ? '1 : '0;
      nxt_rdata    = ext_data_in;
      if (byte_access) begin
        // top lines carry byte address even during reads
        nxt_data.out[`EXT_DATA_W-1 -: `BYTE_ADDR_W] = byte_addr_hi; // R7
        nxt_data.oe[`EXT_DATA_W-1 -: `BYTE_ADDR_W]  = '1; // R7
      end
    end else begin
      // only one address line survives in host mode
      nxt_addr_oe[0] = 1'b1; // R5 R14
      nxt_data.out = core_wdata;
      nxt_data.oe[`EXT_DATA_W-1:`HOST_DATA_LO] =
        core_drive_data ? '1 : '0; // R5
      nxt_rdata[`EXT_DATA_W-1:`HOST_DATA_LO] =
        ext_data_in[`EXT_DATA_W-1:`HOST_DATA_LO];
      nxt_host_oe = host_bus_drive; // R14
      nxt_host_rd = host_bus_in; // R14
    end
  end

  // everything off while in reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_ff    <= '0;
      addr_oe_ff <= '0;
      data_ff    <= '0;
      rdata_ff   <= '0;
      host_ff    <= '0;
      host_oe_ff <= 1'b0;
      host_rd_ff <= '0;
    end else begin
      addr_ff    <= nxt_addr;
      addr_oe_ff <= nxt_addr_oe;
      data_ff    <= nxt_data;
      rdata_ff   <= nxt_rdata;
      host_ff    <= nxt_host;
      host_oe_ff <= nxt_host_oe;
      host_rd_ff <= nxt_host_rd;
    end
  end

  assign ext_address_bus    = addr_ff;
  assign ext_address_oe     = addr_oe_ff;
  assign ext_data_out       = data_ff.out;
  assign ext_data_oe        = data_ff.oe;
  assign core_rdata         = rdata_ff;
  assign host_addr_data_bus = host_ff;
  assign host_bus_oe        = host_oe_ff;
  assign host_bus_rdata     = host_rd_ff;

  // ---------------- second serial port ----------------
  logic [4:0] sp_ff;   // dt, flag in, rfs, tfs, dr
  logic [4:0] nxt_sp;

  // reassigned frame syncs become irq lanes; data pins become flags
  always_comb begin
    if (sport_flag_mode) begin
      nxt_sp = {serial_flag_output, sp1_dr_in, 3'h0}; // R10
    end else begin
      nxt_sp = {sport_dt_core, 1'b0, sp1_rfs_in, sp1_tfs_in, sp1_dr_in};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sp_ff <= '0;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  assign sp1_dt_out        = sp_ff[4];
  assign serial_flag_input = sp_ff[3];
  assign sport_rfs_core    = sp_ff[2];
  assign sport_tfs_core    = sp_ff[1];
  assign sport_dr_core     = sp_ff[0];

  // ---------------- checks ----------------
  strap_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // R3
    $past(rstn) |-> $stable(strap_ff))
    else $error("strap changed after reset");
  mode_status_a: assert property (@(posedge mclk) disable iff (!rstn) // R4
    $past(rstn) |-> mode_host == $past(strap_ff[`MODE_C_BIT]))
    else $error("mode status wrong");
  flag_dir_a: assert property (@(posedge mclk) disable iff (!rstn) // R2
    $past(rstn) |-> flag_pad_oe == $past(flag_dir) &&
    flag_pad_out == $past(flag_value))
    else $error("flag pad drive wrong");
  fixed_flags_a: assert property (@(posedge mclk) disable iff (!rstn) // R13
    $past(rstn) |-> fixed_output_flags == $past(fixed_flag_value))
    else $error("fixed flag wrong");
  full_addr_a: assert property (@(posedge mclk) disable iff (!rstn) // R6
    $past(rstn) && op_mode == MODE_FULL |->
    ext_address_oe == '1 && ext_address_bus == $past(core_addr))
    else $error("address bus not driven");
  host_addr_a: assert property (@(posedge mclk) disable iff (!rstn) // R14
    $past(rstn) && op_mode == MODE_HOST |->
    ext_address_oe == 14'h0001 && host_bus_oe == $past(host_bus_drive))
    else $error("host mode bus wrong");
  byte_addr_a: assert property (@(posedge mclk) disable iff (!rstn) // R7
    $past(rstn && byte_access) && op_mode == MODE_FULL |->
    ext_data_out[23:16] == $past(byte_addr_hi) && ext_data_oe[23:16] == 8'hFF)
    else $error("byte address missing");
  full_host_off_a: assert property (@(posedge mclk) disable iff (!rstn) // R5
    op_mode == MODE_FULL |-> !host_bus_oe ##1 host_bus_rdata == 16'h0000)
    else $error("host port active in full mode");
  sport_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // R10
    $past(rstn && sport_flag_mode) |->
    sp1_dt_out == $past(serial_flag_output) &&
    serial_flag_input == $past(sp1_dr_in) && !sport_dr_core)
    else $error("serial pin reassignment wrong");
endmodule
`default_nettype wire

//--- pin_share_cfg.svh
// constants for the boot-strap and pin-sharing logic
// assumes one clock domain and straps held stable through reset
//
// Summary of operation
// [R1] straps sampled only while reset is asserted
// [R2] strap pins become flag pins after reset
// [R3] captured mode holds until next reset
// [R4] memory-mode strap 0 selects full memory mode
// [R5] full mode: byte bus; host mode: host port
// [R6] full mode drives 14-line address bus
// [R7] data bus top 8 carry byte addresses
// [R8] irq and flag functions coexist on pins
// [R9] masked-in irq vectors whoever drives the pin
// [R10] control bit reassigns second serial port pins
// [R11] one shared irq pin edge or level
// [R12] one edge, two level, three configurable irqs
// [R13] three fixed flags always drive outputs
// [R14] host mode exposes 16-line address/data bus
// [R15] straps registered at release, reset-only mode
// [R16] board holds straps stable during reset
`ifndef PIN_SHARE_CFG_SVH
`define PIN_SHARE_CFG_SVH
`define STRAP_W        4
`define MODE_C_BIT     2
`define FULL_MODE_CODE 1'b0
`define FLAG_W         8
`define FIXED_FLAG_W   3
`define EXT_ADDR_W     14
`define EXT_DATA_W     24
`define BYTE_ADDR_W    8
`define HOST_BUS_W     16
`define HOST_DATA_LO   8
`define IRQ_N          6
`define LANE_CFG_IRQ   0
`define LANE_LVL_ZERO  1
`define LANE_LVL_ONE   2
`define LANE_EDGE      3
`define LANE_SP_IRQ0   4
`define LANE_SP_IRQ1   5
`define PIN_CFG_IRQ    7
`define PIN_LVL_ZERO   6
`define PIN_LVL_ONE    5
`define PIN_EDGE       4
`define SENSE_LEVEL    0
`define SENSE_EDGE     1
`define SENSE_CONFIG   2
`endif

//--- pin_share_pkg.sv
// types shared by the pin-sharing logic
// assumes pin_share_cfg.svh is on the include path
`default_nettype none
`include "pin_share_cfg.svh"
package pin_share_pkg;
  // operating mode, fixed at reset
  typedef enum logic [0:0] {
    MODE_FULL = 1'b0,
    MODE_HOST = 1'b1
  } op_mode_e;
  // one group of pad drivers
  typedef struct packed {
    logic [`FLAG_W-1:0] out;
    logic [`FLAG_W-1:0] oe;
  } flag_pad_s;
  // external data bus drivers
  typedef struct packed {
    logic [`EXT_DATA_W-1:0] out;
    logic [`EXT_DATA_W-1:0] oe;
  } data_pad_s;
endpackage
`default_nettype wire

//--- irq_sense.sv
// one external interrupt lane: level or falling-edge sensing
// assumes the pin level is synchronous to mclk, active low
`timescale 1ns/10ps
`default_nettype none
module irq_sense #(
  parameter int SENSE = 2  // 0 level only, 1 edge only, 2 configurable
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin_level,
  input  wire logic edge_sel,
  input  wire logic mask_en,
  output var  logic req
);
  logic prev_ff;     // pin level one cycle ago
  logic req_ff;      // registered request
  logic nxt_prev;
  logic nxt_req;
  logic use_edge;    // effective sensitivity

  // fixed lanes ignore the select so software cannot change them
  assign use_edge = (SENSE == 1) || ((SENSE == 2) && edge_sel); // R12 R11

  // request follows mask whoever drives the pin
  always_comb begin
    nxt_prev = pin_level;
    if (use_edge) begin
      nxt_req = mask_en && prev_ff && !pin_level; // R9
    end else begin
      nxt_req = mask_en && !pin_level; // R9
    end
  end

  // idle pin is high, so prev starts high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b1;
      req_ff  <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      req_ff  <= nxt_req;
    end
  end

  assign req = req_ff;

  edge_pulse_a: assert property (@(posedge mclk) disable iff (!rstn) // R11
    use_edge && mask_en && prev_ff && !pin_level |=> req ##1
    ($past(pin_level) || req == $past(mask_en && prev_ff)))
    else $error("edge request missed");
  level_follow_a: assert property (@(posedge mclk) disable iff (!rstn) // R12
    !use_edge |=> req == $past(mask_en && !pin_level))
    else $error("level request wrong");
endmodule
`default_nettype wire

//--- board_model.sv
// board side of the flag pads: pull-ups, strap drive, external drivers
// assumes the testbench sets strap and drive levels at clock edges
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input  wire logic       rstn,
  input  wire logic [3:0] strap_level,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  output var  logic [7:0] pad
);
  // wired pad level; straps drive only while reset is low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe[i]) begin
        pad[i] = dev_out[i];  // device drive wins
      end else if (!rstn && i < 4) begin
        pad[i] = strap_level[i];
      end else if (ext_oe[i]) begin
        pad[i] = ext_val[i];  // external part pulls the line
      end else begin
        pad[i] = 1'h1;  // pull-up keeps irq lines idle high
      end
    end
  end
endmodule
`default_nettype wire

//--- boot_mode_strap_and_pin_sharing_tb_top.sv
// testbench for strap capture, mode select and shared pins
// assumes board_model resolves the flag pads with pull-ups
`timescale 1ns/10ps
`default_nettype none
module boot_mode_strap_and_pin_sharing_tb_top;
  logic        mclk, rstn, cfg_irq_edge_sel, mode_host, core_drive_data;
  logic        byte_access, host_bus_drive, host_bus_oe, sport_flag_mode;
  logic        sp1_rfs_in, sp1_tfs_in, sp1_dr_in, sp1_dt_out;
  logic        sport_dt_core, serial_flag_output, serial_flag_input;
  logic        sport_rfs_core, sport_tfs_core, sport_dr_core;
  logic [7:0]  flag_pad_in, flag_pad_out, flag_pad_oe, flag_dir;
  logic [7:0]  flag_value, flag_read, byte_addr_hi, ext_val, ext_oe;
  logic [2:0]  fixed_flag_value, fixed_output_flags;
  logic [5:0]  interrupt_mask_bits, irq_request;
  logic [1:0]  sport_irq_edge_sel;
  logic [3:0]  strap_captured, strap_level;
  logic [13:0] core_addr, ext_address_bus, ext_address_oe;
  logic [23:0] core_wdata, ext_data_in, ext_data_out, ext_data_oe;
  logic [23:0] core_rdata;
  logic [15:0] host_bus_in, host_bus_wdata, host_addr_data_bus;
  logic [15:0] host_bus_rdata;
  int          error_cnt, tests_run;

  pin_share i_dut (.mclk, .rstn, .flag_pad_in, .flag_pad_out, .flag_pad_oe,
    .flag_dir, .flag_value, .flag_read, .fixed_flag_value,
    .fixed_output_flags, .interrupt_mask_bits, .cfg_irq_edge_sel,
    .sport_irq_edge_sel, .irq_request, .mode_host, .strap_captured,
    .core_addr, .ext_address_bus, .ext_address_oe, .core_wdata,
    .core_drive_data, .byte_access, .byte_addr_hi, .ext_data_in,
    .ext_data_out, .ext_data_oe, .core_rdata, .host_bus_in, .host_bus_wdata,
    .host_bus_drive, .host_addr_data_bus, .host_bus_oe, .host_bus_rdata,
    .sport_flag_mode, .sp1_rfs_in, .sp1_tfs_in, .sp1_dr_in, .sp1_dt_out,
    .sport_dt_core, .serial_flag_output, .serial_flag_input,
    .sport_rfs_core, .sport_tfs_core, .sport_dr_core);

  board_model i_board (.rstn, .strap_level, .ext_val, .ext_oe,
    .dev_out(flag_pad_out), .dev_oe(flag_pad_oe), .pad(flag_pad_in));

  // 100 ns clock
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // one compare for every result; four-state so unknowns never match
  task automatic chk(input string nm, input logic [23:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // wait n edges, then sample mid-cycle where outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // reset with a strap pattern; flag pad enables must be cleared meanwhile
  task automatic do_reset(input logic [3:0] s);
    @(posedge mclk);
    strap_level <= s;
    flag_dir <= 8'h00;
    rstn <= 1'h0;
    cyc(2);
    chk("oe in reset", 24'h0, flag_pad_oe);
    @(posedge mclk);
    rstn <= 1'h1;
    cyc(1);
    chk("strap", 24'(s), strap_captured);
    chk("mode", 24'(s[2]), mode_host);
  endtask

  // full mode buses: address, data, byte address on top lane
  task automatic t_full();
    do_reset(4'hA);
    @(posedge mclk);
    core_addr <= 14'h2A5C;
    core_wdata <= 24'h123456;
    core_drive_data <= 1'h1;
    ext_data_in <= 24'hABCDEF;
    host_bus_drive <= 1'h1;
    cyc(1);
    chk("addr", 24'h2A5C, ext_address_bus);
    chk("addr oe", 24'h3FFF, ext_address_oe);
    chk("data", 24'h123456, ext_data_out);
    chk("data oe", 24'hFFFFFF, ext_data_oe);
    chk("rdata", 24'hABCDEF, core_rdata);
    chk("host oe", 24'h0, host_bus_oe);
    @(posedge mclk);
    core_drive_data <= 1'h0;
    byte_access <= 1'h1;
    byte_addr_hi <= 8'hC3;
    cyc(1);
    chk("byte addr", 24'hC3, ext_data_out[23:16]);
    chk("byte oe", 24'hFF0000, ext_data_oe);
    @(posedge mclk);
    byte_access <= 1'h0;
  endtask

  // strap pins after reset: flags only, mode unchanged
  task automatic t_flags();
    @(posedge mclk);
    ext_oe <= 8'h0F;
    ext_val <= 8'h04;
    cyc(2);
    chk("mode lock", 24'h0, mode_host);
    chk("strap lock", 24'hA, strap_captured);
    chk("flag in", 24'hF4, flag_read);
    @(posedge mclk);
    ext_oe <= 8'h00;
    flag_dir <= 8'h0F;
    flag_value <= 8'h05;
    fixed_flag_value <= 3'h5;
    cyc(2);
    chk("flag oe", 24'h0F, flag_pad_oe);
    chk("flag out", 24'h5, flag_pad_out[3:0]);
    chk("flag rd", 24'hF5, flag_read);
    chk("fixed", 24'h5, fixed_output_flags);
    @(posedge mclk);
    fixed_flag_value <= 3'h2;
    flag_dir <= 8'h00;
    cyc(1);
    chk("fixed", 24'h2, fixed_output_flags);
  endtask

  // count requests of one lane after its pin falls and stays low
  task automatic edge_cnt(input int lane, input logic [7:0] pin);
    int n = 0;
    @(posedge mclk);
    ext_oe <= 8'h00;
    interrupt_mask_bits <= 6'(1 << lane);
    cyc(2);
    @(posedge mclk);
    ext_oe <= pin;
    ext_val <= 8'h00;
    repeat (6) begin
      @(negedge mclk);
      if (irq_request[lane] === 1'h1) n++;
    end
    chk("edge pulses", 24'h1, 24'(n));
    @(posedge mclk);
    ext_oe <= 8'h00;
  endtask

  // shared irq pins: own flag drive and external drive both request
  task automatic t_irq();
    @(posedge mclk);
    interrupt_mask_bits <= 6'h01;
    flag_dir <= 8'h80;
    flag_value <= 8'h00;
    cyc(2);
    chk("self irq", 24'h01, irq_request);
    @(posedge mclk);
    interrupt_mask_bits <= 6'h00;
    cyc(2);
    chk("masked", 24'h0, irq_request);
    @(posedge mclk);
    flag_dir <= 8'h00;
    interrupt_mask_bits <= 6'h06;
    ext_oe <= 8'h60;
    ext_val <= 8'h00;
    cyc(2);
    chk("level irq", 24'h06, irq_request);
    edge_cnt(3, 8'h10);
    cfg_irq_edge_sel <= 1'h1;
    edge_cnt(0, 8'h80);
    cfg_irq_edge_sel <= 1'h0;
  endtask

  // second serial port in normal and flag/irq roles
  task automatic t_serial();
    @(posedge mclk);
    sp1_rfs_in <= 1'h1;
    sp1_dr_in <= 1'h1;
    sport_dt_core <= 1'h1;
    interrupt_mask_bits <= 6'h30;
    cyc(1);
    chk("sp core", 24'h5,
        {sport_rfs_core, sport_tfs_core, sport_dr_core});
    chk("sp dt", 24'h1, sp1_dt_out);
    chk("sp irq off", 24'h0, irq_request);
    @(posedge mclk);
    sport_flag_mode <= 1'h1;
    sport_dt_core <= 1'h0;
    serial_flag_output <= 1'h1;
    sp1_rfs_in <= 1'h0;
    cyc(2);
    chk("flag dt", 24'h1, sp1_dt_out);
    chk("flag in", 24'h1, serial_flag_input);
    chk("sp irq", 24'h30, irq_request);
    chk("sp core off", 24'h0, sport_rfs_core);
    // serial irq lanes switched to edge: one pulse per fall
    @(posedge mclk);
    sport_irq_edge_sel <= 2'h3;
    sp1_rfs_in <= 1'h1;
    sp1_tfs_in <= 1'h1;
    cyc(1);
    chk("sp idle", 24'h0, irq_request);
    @(posedge mclk);
    sp1_rfs_in <= 1'h0;
    sp1_tfs_in <= 1'h0;
    cyc(1);
    chk("sp edge", 24'h30, irq_request);
    @(posedge mclk);
    sport_flag_mode <= 1'h0;
    sport_irq_edge_sel <= 2'h0;
    cyc(0);
    chk("sp pulse", 24'h0, irq_request);
  endtask

  // host mode: multiplexed port bus, one address line, upper data
  task automatic t_host();
    do_reset(4'h4);
    @(posedge mclk);
    host_bus_wdata <= 16'hBEEF;
    host_bus_in <= 16'h1234;
    core_drive_data <= 1'h1;
    ext_oe <= 8'h04;
    ext_val <= 8'h00;
    cyc(2);
    chk("mode lock", 24'h1, mode_host);
    chk("host bus", 24'hBEEF, host_addr_data_bus);
    chk("host oe", 24'h1, host_bus_oe);
    chk("host rd", 24'h1234, host_bus_rdata);
    chk("addr oe", 24'h0001, ext_address_oe);
    chk("data oe", 24'hFFFF00, ext_data_oe);
    chk("rdata lo", 24'h0, core_rdata[7:0]);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence; every input defined at time zero
  initial begin
    {rstn, cfg_irq_edge_sel, core_drive_data, byte_access} = 4'h0;
    {host_bus_drive, sport_flag_mode, sp1_tfs_in} = 3'h0;
    {sp1_rfs_in, sp1_dr_in, sport_dt_core, serial_flag_output} = 4'h0;
    {flag_dir, flag_value, byte_addr_hi, ext_val, ext_oe} = 40'h0;
    {fixed_flag_value, interrupt_mask_bits, sport_irq_edge_sel} = 11'h0;
    {core_addr, core_wdata, ext_data_in} = 62'h0;
    {host_bus_in, host_bus_wdata} = 32'h0;
    strap_level = 4'hA;
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    t_full();
    t_flags();
    t_irq();
    t_serial();
    t_host();
    close_out();
  end

  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
